/* File: design/acs_cfg.svh */
// Constants for the conversion sequencer: register offsets, field positions, reset values and timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_ADDR_W        4
`define ACS_OFF_CTRL0     4'h0
`define ACS_OFF_CTRL1     4'h1
`define ACS_OFF_DATA_HI   4'h2
`define ACS_OFF_DATA_LO   4'h3
`define ACS_OFF_STATUS    4'h4
`define ACS_BIT_CEN       7
`define ACS_BIT_REFLO     6
`define ACS_BIT_REFOUT    5
`define ACS_BIT_CONTINUOUS_MODE      4
`define ACS_BIT_REFHI     1
`define ACS_CTRL0_RST     8'h00
`define ACS_REFHI_RST     1'b1
`define ACS_IDLE_CYC      160
`define ACS_PWRUP_CYC     40
`define ACS_CONV_CYC      5129
`define ACS_CONTINUOUS_MODE_CYC      256
`define ACS_RES_W         13
`endif

/* File: design/acs_pkg.sv */
// Types shared by the conversion sequencer files.
// Assumes acs_cfg.svh is on the include path.
`include "acs_cfg.svh"
package acs_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_PWRUP,
    ACS_CONV
  } acs_state_t;

  // Control fields written by software.
  typedef struct packed {
    logic       continuous_mode;
    logic       ref_output_en;
    logic [1:0] ref_level;
    logic [3:0] input_select;
  } acs_ctrl_t;
endpackage

/* File: design/acs_sequencer.sv */
// Conversion sequencer for a sigma-delta converter: control registers, power management and result capture.
// Assumes a register master on a plain strobe port and a modulator that presents its result when asked.
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_sequencer #(
  parameter int RES_W   = `ACS_RES_W,
  parameter int TIMER_W = 13
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [`ACS_ADDR_W-1:0]  addr_in,
  input  wire logic [7:0]              wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  input  wire logic [RES_W-1:0]        mod_result_in,
  output logic      [7:0]              rdata_out,
  output logic      [3:0]              input_select_out,
  output logic      [1:0]              ref_level_out,
  output logic                         ref_output_en_out,
  output logic                         analog_power_out,
  output logic                         converting_out,
  output logic                         conv_done_irq_out
);
  localparam logic [TIMER_W-1:0] PWRUP_LOAD = TIMER_W'(`ACS_PWRUP_CYC - 1);
  localparam logic [TIMER_W-1:0] CONV_LOAD  = TIMER_W'(`ACS_CONV_CYC - 1);
  localparam logic [TIMER_W-1:0] CONTINUOUS_MODE_LOAD  = TIMER_W'(`ACS_CONTINUOUS_MODE_CYC - 1);
  localparam logic [TIMER_W-1:0] IDLE_LOAD  = TIMER_W'(`ACS_IDLE_CYC - 1);

  acs_pkg::acs_ctrl_t  ctrl;          // Software control fields.
  acs_pkg::acs_state_t state;         // Sequencer state.
  logic                conversion_enable; // Enable bit as software sees it.
  logic                powered;       // Analog section powered.
  logic                first_done;    // First result of the current run already written.
  logic [7:0]          result_high_byte;  // Upper result byte.
  logic [7:0]          result_low_byte;   // Lower result byte.
  logic                timer_load;    // Reloads the shared delay counter.
  logic [TIMER_W-1:0]  timer_value;   // Value loaded into the counter.
  logic                timer_zero;    // Counter has run out.
  logic                start_wr;      // Software start request.
  logic                ctrl0_wr;      // Write to control register 0.
  logic                done;          // Conversion finishes this cycle.
  logic                continuous_mode_stop;     // Continuous run ended by software.

  initial begin
    if (RES_W != `ACS_RES_W || TIMER_W < 13) begin
      $error("acs_sequencer parameters out of range");
    end
  end

  // A start is a write of 1 to the enable bit; a 0 is ignored.
  assign ctrl0_wr = wr_in && (addr_in == `ACS_OFF_CTRL0);
  assign start_wr = ctrl0_wr && wdata_in[`ACS_BIT_CEN];
  assign done     = (state == acs_pkg::ACS_CONV) && timer_zero && !start_wr;
  // Only a run that has already produced a result is stopped by the mode bit.
  assign continuous_mode_stop = (state == acs_pkg::ACS_CONV) && first_done && !ctrl.continuous_mode && !start_wr;

  // Picks what the shared counter should load.
  always_comb begin
    timer_load  = 1'b0;
    timer_value = IDLE_LOAD;
    if (start_wr) begin
      timer_load  = 1'b1;
      timer_value = powered ? CONV_LOAD : PWRUP_LOAD;
    end else if (state == acs_pkg::ACS_PWRUP && timer_zero) begin
      timer_load  = 1'b1;
      timer_value = CONV_LOAD;
    end else if (done && ctrl.continuous_mode) begin
      timer_load  = 1'b1;
      timer_value = CONTINUOUS_MODE_LOAD;
    end else if (done) begin
      timer_load  = 1'b1;
      timer_value = IDLE_LOAD;
    end else if (continuous_mode_stop) begin
      timer_load  = 1'b1;
      timer_value = IDLE_LOAD;
    end
  end

  acs_timer #(
    .W (TIMER_W)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .load_in    (timer_load),
    .value_in   (timer_value),
    .zero_out   (timer_zero)
  );

  // Control fields other than the enable bit.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl.input_select    <= 4'h0;
      ctrl.continuous_mode <= 1'b0;
      ctrl.ref_output_en   <= 1'b0;
      ctrl.ref_level       <= {`ACS_REFHI_RST, 1'b0};
    end else if (ctrl0_wr) begin
      ctrl.input_select    <= wdata_in[3:0];
      ctrl.continuous_mode <= wdata_in[`ACS_BIT_CONTINUOUS_MODE];
      ctrl.ref_output_en   <= wdata_in[`ACS_BIT_REFOUT];
      ctrl.ref_level[0]    <= wdata_in[`ACS_BIT_REFLO];
    end else if (wr_in && addr_in == `ACS_OFF_CTRL1) begin
      ctrl.ref_level[1]    <= wdata_in[`ACS_BIT_REFHI];
    end
  end

  // Enable bit: set by a start, cleared by hardware at the first result.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conversion_enable <= 1'b0;
    end else if (start_wr) begin
      conversion_enable <= 1'b1;
    end else if (done) begin
      conversion_enable <= 1'b0;
    end
  end

  // Sequencer states; a start always wins and restarts.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= acs_pkg::ACS_IDLE;
    end else if (start_wr) begin
      state <= powered ? acs_pkg::ACS_CONV : acs_pkg::ACS_PWRUP;
    end else begin
      unique case (state)
        acs_pkg::ACS_IDLE: begin
          state <= acs_pkg::ACS_IDLE;
        end
        acs_pkg::ACS_PWRUP: begin
          if (timer_zero) begin
            state <= acs_pkg::ACS_CONV;
          end
        end
        acs_pkg::ACS_CONV: begin
          // A continuous run that has produced a result stops at once when software clears the mode bit.
          if (continuous_mode_stop) begin
            state <= acs_pkg::ACS_IDLE;
          end else if (done && !ctrl.continuous_mode) begin
            state <= acs_pkg::ACS_IDLE;
          end else begin
            state <= acs_pkg::ACS_CONV;
          end
        end
        default: begin
          state <= acs_pkg::ACS_IDLE;
        end
      endcase
    end
  end

  // Tracks whether a continuous run has produced its first result.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_done <= 1'b0;
    end else if (start_wr) begin
      first_done <= 1'b0;
    end else if (done) begin
      first_done <= 1'b1;
    end
  end

  // Power: on when a request arrives, off after the idle count runs out.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      powered <= 1'b0;
    end else if (start_wr || state != acs_pkg::ACS_IDLE) begin
      powered <= 1'b1;
    end else if (timer_zero) begin
      powered <= 1'b0;
    end
  end

  // Result capture; low byte keeps result bits 4:0 in 7:3 and zeros in 2:0.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end else if (done) begin
      result_high_byte <= mod_result_in[RES_W-1 -: 8];
      result_low_byte  <= {mod_result_in[4:0], 3'h0};
    end
  end

  // Interrupt pulse in the cycle the result is written; also for continuous results after the enable bit has cleared.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_done_irq_out <= 1'b0;
    end else begin
      conv_done_irq_out <= done;
    end
  end

  // Register outputs toward the analog section.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_select_out  <= 4'h0;
      ref_level_out     <= 2'h0;
      ref_output_en_out <= 1'b0;
      analog_power_out  <= 1'b0;
      converting_out    <= 1'b0;
    end else begin
      input_select_out  <= ctrl.input_select;
      ref_level_out     <= ctrl.ref_level;
      ref_output_en_out <= ctrl.ref_output_en;
      analog_power_out  <= powered || start_wr;
      converting_out    <= (state == acs_pkg::ACS_CONV) && !done;
    end
  end

  // Read data in the cycle after the read strobe; unmapped reads return zero.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        `ACS_OFF_CTRL0: begin
          rdata_out <= {conversion_enable, ctrl.ref_level[0], ctrl.ref_output_en,
                        ctrl.continuous_mode, ctrl.input_select};
        end
        `ACS_OFF_CTRL1: begin
          rdata_out <= {6'h00, ctrl.ref_level[1], 1'b0};
        end
        `ACS_OFF_DATA_HI: begin
          rdata_out <= result_high_byte;
        end
        `ACS_OFF_DATA_LO: begin
          rdata_out <= result_low_byte;
        end
        `ACS_OFF_STATUS: begin
          rdata_out <= {5'h00, first_done, powered, state != acs_pkg::ACS_IDLE};
        end
        default: begin
          rdata_out <= 8'h00;
        end
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Conversion length from entry into the conversion state to the completion cycle.
  logic [TIMER_W-1:0] conv_age;  // Cycles since the last conversion began.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_age <= '0;
    end else if (state != acs_pkg::ACS_CONV || done || start_wr) begin
      conv_age <= '0;
    end else begin
      conv_age <= conv_age + 1'b1;
    end
  end

  single_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (done && !first_done) |-> (conv_age == CONV_LOAD))
    else $error("first conversion length wrong");

  continuous_mode_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (done && first_done) |-> (conv_age == CONTINUOUS_MODE_LOAD))
    else $error("continuous period wrong");

  irq_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    done |=> (conv_done_irq_out && ({result_high_byte, result_low_byte[7:3]} == $past(mod_result_in))))
    else $error("interrupt not with result");

  cen_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (done && !start_wr) |=> !conversion_enable)
    else $error("enable not cleared at end");

  cen_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ctrl0_wr && !wdata_in[`ACS_BIT_CEN] && !done) |=> conversion_enable == $past(conversion_enable))
    else $error("zero write changed enable");

  pwrup_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (start_wr && !powered) |=> (state == acs_pkg::ACS_PWRUP) [*8])
    else $error("power-up skipped");

  single_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (done && !ctrl.continuous_mode && !start_wr) |=> state == acs_pkg::ACS_IDLE)
    else $error("single shot did not stop");

  irq_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == acs_pkg::ACS_IDLE) |=> !conv_done_irq_out)
    else $error("interrupt while disabled");

  // The checks below guard the completion pulse and the start, stop and power paths.
  // Each one looks one cycle ahead of the event that it watches.

  // The completion pulse never lasts more than one cycle.
  irq_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    conv_done_irq_out |=> !conv_done_irq_out)
    else $error("interrupt pulse too long");

  // A start while powered restarts the count from zero.
  restart_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (start_wr && powered) |=> (state == acs_pkg::ACS_CONV && conv_age == '0))
    else $error("restart did not begin anew");

  // Clearing the mode bit ends a continuous run at once after its first result.
  continuous_mode_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    continuous_mode_stop |=> (state == acs_pkg::ACS_IDLE))
    else $error("continuous run not stopped");

  // A start sets the enable bit that software reads back.
  cen_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    start_wr |=> conversion_enable)
    else $error("enable not set by start");

  // The enable bit stays up while a first conversion is under way.
  cen_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (state != acs_pkg::ACS_IDLE && conversion_enable && !done) |=> conversion_enable)
    else $error("enable dropped early");

  // A start always powers the analog section.
  wake_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    start_wr |=> powered)
    else $error("start did not wake converter");

  // The section powers down once the idle count runs out.
  power_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == acs_pkg::ACS_IDLE && powered && timer_zero && !start_wr) |=> !powered)
    else $error("idle power-down missed");
endmodule

/* File: design/acs_timer.sv */
// Down counter used for the power-up, conversion and idle delays.
// Assumes a single synchronous clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module acs_timer #(
  parameter int W = 13
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  output logic              zero_out
);
  logic [W-1:0] count;  // Remaining cycles.

  initial begin
    if (W < 2) begin
      $error("acs_timer width too small");
    end
  end

  // Loads a new value or counts down to zero and holds.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (load_in) begin
      count <= value_in;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // Flags a spent count.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zero_out <= 1'b1;
    end else if (load_in) begin
      zero_out <= (value_in == '0);
    end else begin
      zero_out <= (count <= {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule

/* File: test/acs_mod_model.sv */
// Behavioural model of the modulator and input multiplexer on the far side of the sequencer.
// Assumes the sequencer powers the analog side and samples the result when a conversion completes.
`timescale 1ns/1ps
module acs_mod_model (
  input  wire logic        sys_clk_in,
  input  wire logic [3:0]  input_select_in,
  input  wire logic        analog_power_in,
  output logic      [12:0] mod_result_out
);
  logic [12:0] level = 13'h0AAA; // Value now presented to the sequencer.

  // While powered the result is fixed by the routed input, so each channel has its own code.
  // Unpowered, the output toggles every cycle, so a stale sample alternates between the last valid code and its inverse.
  always @(posedge sys_clk_in) begin
    if (analog_power_in) begin
      level <= {input_select_in, 9'h0B3};
    end else begin
      level <= ~level;
    end
  end

  assign mod_result_out = level;
endmodule

/* File: test/test_acs_sequencer.sv */
// Self-checking bench for the conversion sequencer, driven through its register strobes.
// Assumes the design files and acs_cfg.svh are compiled first.
`timescale 1ns/1ps
`include "acs_cfg.svh"
module test_acs_sequencer;
  localparam int CONV = `ACS_CONV_CYC;  // Conversion length.
  localparam int PWR  = `ACS_PWRUP_CYC; // Power-up delay.
  logic        sys_clk = 1'b0;          // System clock.
  logic        rst_n;                   // Reset, active low.
  logic [3:0]  addr;                    // Register address.
  logic [7:0]  wdata;                   // Write data.
  logic        wr;                      // Write strobe.
  logic        rd;                      // Read strobe.
  logic [12:0] mod_res;                 // Modulator result.
  logic [7:0]  rdata;                   // Read data.
  logic [3:0]  sel;                     // Input select.
  logic [1:0]  lvl;                     // Reference level.
  logic        refen;                   // Reference to pin.
  logic        pwr;                     // Analog power.
  logic        irq;                     // Completion pulse.
  logic        busy;                    // Conversion running.
  logic [7:0]  d;                       // Last read value.
  logic [12:0] r;                       // Expected raw result.
  int          failures;                // Mismatch count.
  int          checked;                 // Comparison count.
  int          n;                       // Cycle count.

  // Clock at 250 MHz.
  always #2 sys_clk = ~sys_clk;

  acs_sequencer acs_sequencer_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .mod_result_in(mod_res), .rdata_out(rdata), .input_select_out(sel),
    .ref_level_out(lvl), .ref_output_en_out(refen), .analog_power_out(pwr), .converting_out(busy),
    .conv_done_irq_out(irq));

  acs_mod_model acs_mod_model_i (.sys_clk_in(sys_clk), .input_select_in(sel), .analog_power_in(pwr),
    .mod_result_out(mod_res));

  // Compares a byte-wide result.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Compares a cycle count against an allowed range.
  task automatic chk_n(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // One-cycle write, entered just after a rising edge.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  // One-cycle read; data stand in the following cycle only.
  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask

  // Counts edges until a completion pulse is seen, or the limit runs out.
  task automatic wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    results();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; failures = 0; checked = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values, then an unmapped read and an unmapped write.
    rd_reg(4'h0); chk(d, 8'h00);
    rd_reg(4'h1); chk(d & 8'h02, 8'h02);
    rd_reg(4'hF); chk(d, 8'h00);
    wr_reg(4'hE, 8'hFF); rd_reg(4'h0); chk(d, 8'h00);
    // Reference codes 0 to 2, with the pin output only when the internal reference is on.
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h1, {6'h00, i[1], 1'b0});
      @(posedge sys_clk);
      wr_reg(4'h0, {1'b0, i[0], i != 0, 1'b0, 4'(i + 5)});
      repeat (2) @(posedge sys_clk);
      chk({6'h00, lvl}, 8'(i));
      chk({4'h0, sel}, 8'(i + 5));
      chk({7'h00, refen}, 8'(i != 0));
    end
    // Single shot from power-down; a write of 0 to the enable bit must not stop it.
    wr_reg(4'h0, 8'h83);
    rd_reg(4'h0); chk(d, 8'h83);
    wr_reg(4'h0, 8'h03);
    rd_reg(4'h0); chk(d, 8'h83);
    wait_irq(7000); chk_n(n + 5, CONV + PWR, CONV + PWR + 3);
    r = {4'h3, 9'h0B3};
    rd_reg(4'h2); chk(d, r[12:5]);
    rd_reg(4'h3); chk(d & 8'hF8, {r[4:0], 3'b000});
    rd_reg(4'h0); chk(d, 8'h03);
    wait_irq(150); chk_n(n, 150, 150);
    chk({7'h00, pwr}, 8'h01);
    repeat (20) @(posedge sys_clk);
    chk({7'h00, pwr}, 8'h00);
    // A second start in mid-conversion restarts the full count.
    wr_reg(4'h0, 8'h86);
    repeat (1000) @(posedge sys_clk);
    chk({7'h00, busy}, 8'h01);
    wr_reg(4'h0, 8'h86);
    wait_irq(7000); chk_n(n, CONV, CONV + 3);
    // Continuous mode while still powered: first result, then one every 256 cycles.
    wr_reg(4'h0, 8'h97);
    wait_irq(7000); chk_n(n, CONV, CONV + 3);
    for (int k = 0; k < 3; k++) begin
      wait_irq(300); chk_n(n, `ACS_CONTINUOUS_MODE_CYC, `ACS_CONTINUOUS_MODE_CYC);
    end
    rd_reg(4'h0); chk(d, 8'h17);
    r = {4'h7, 9'h0B3};
    rd_reg(4'h2); chk(d, r[12:5]);
    // Clearing the continuous bit stops the results and their pulses.
    wr_reg(4'h0, 8'h07);
    wait_irq(600); chk_n(n, 600, 600);
    chk({7'h00, busy}, 8'h00);
    results();
  end
endmodule
